// ==== rtl/scram_trip_voting_logic.sv ====
// Trip voting, actuation, annunciation and trip logging of a protection
// system with two trip systems of two automatic and one manual logic each.
// Assumes all inputs are synchronous to CLK_SYS; the sensor and button inputs
// and the pilot solenoid outputs are high while healthy and low while tripped.
`timescale 1ns/1ps
`default_nettype none
`include "scram_trip_defs.svh"

//////////////////////////////////////////////////////////////////////////////

// Behaviour
// RULE1 - Two trip systems, two automatic, one manual.
// RULE2 - Healthy is asserted; trip means deasserted.
// RULE3 - Bypass acts only while its input asserted.
// RULE4 - Rod scrams only when both pilots drop.
// RULE5 - One pilot per system for every rod.
// RULE6 - Backup solenoids assert only when both tripped.
// RULE7 - Backup assertion inserts every rod regardless.
// RULE8 - Open channel trips logic, actuators, system pilots.
// RULE9 - Single system trip never scrams the rods.
// RULE10 - Manual button trips only its own system.
// RULE11 - Manual logic testable, resettable per system.
// RULE12 - Power loss trips everything, scramming rods.
// RULE13 - Reset after delay and cleared conditions only.
// RULE14 - One latched indication per monitored variable.
// RULE15 - Each trip system drives its trip indication.
// RULE16 - Channel trip sounds alarm; acknowledge silences.
// RULE17 - Indications latch; reset ignored while condition present.
// RULE18 - Trips reported by channel, in occurrence order; trips waiting over several cycles are merged and sent lowest index first.
// RULE19 - Information outputs derive from relay-level signals.
// RULE20 - Either automatic logic trips its system.
// RULE21 - Steam isolation bypassed outside run mode.
// RULE22 - Reset delay counter restarts on every trip; code restarts only on a fresh unbypassed channel trip or a supply loss.
module scram_trip_voting_logic #(
    parameter logic [`STV_CNT_W-1:0] RESET_DELAY_CYC =
        `STV_CNT_W'(`STV_RESET_DELAY_CYC)
) (
    // Clock, reset and enable.
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    // Sensor channel contacts, one bit per monitored variable.
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_ONE_SYS_A,
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_TWO_SYS_A,
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_ONE_SYS_B,
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_TWO_SYS_B,
    // Manual bypass contacts, normally open.
    input wire logic [`STV_NVAR-1:0] BYP_AUTO_ONE_SYS_A,
    input wire logic [`STV_NVAR-1:0] BYP_AUTO_TWO_SYS_A,
    input wire logic [`STV_NVAR-1:0] BYP_AUTO_ONE_SYS_B,
    input wire logic [`STV_NVAR-1:0] BYP_AUTO_TWO_SYS_B,
    // Mode selector and supply health.
    input wire logic MODE_RUN,
    input wire logic POWER_OK,
    // Operator panel.
    input wire logic MAN_BUTTON_SYS_A_OK,
    input wire logic MAN_BUTTON_SYS_B_OK,
    input wire logic RESET_SW_SYS_A,
    input wire logic RESET_SW_SYS_B,
    input wire logic ALARM_ACK,
    // Solenoid drives.
    output logic [`STV_NROD-1:0] PILOT_SOL_SYS_A,
    output logic [`STV_NROD-1:0] PILOT_SOL_SYS_B,
    output logic [`STV_NBACKUP-1:0] BACKUP_SOL,
    output logic [`STV_NROD-1:0] ROD_SCRAM_CMD,
    // Annunciation.
    output logic SYS_A_TRIP_IND,
    output logic SYS_B_TRIP_IND,
    output logic [`STV_NVAR-1:0] VAR_TRIP_IND,
    output logic AUDIBLE_ALARM,
    output logic RESET_PERMIT_SYS_A,
    output logic RESET_PERMIT_SYS_B,
    // Trip logger.
    output logic LOG_VALID,
    output logic [`STV_ID_W-1:0] LOG_CHAN_ID
);

    //////////////////////////////////////////////////////////////////////////

    scram_trip_pkg::stv_state_t st_ff;
    scram_trip_pkg::stv_state_t nxt_st;

    logic [`STV_NCH-1:0] sens_raw;
    logic [`STV_NCH-1:0] relay_trip;
    logic [`STV_NCH-1:0] byp_eff;
    logic [`STV_NCH-1:0] eff_trip;
    logic [`STV_NCH-1:0] new_trip;
    logic [`STV_NCH-1:0] new_eff;
    logic [`STV_NCH-1:0] batch_left;
    logic [`STV_NLOGIC-1:0] cause;
    logic [`STV_NVAR-1:0] var_trip;
    logic [`STV_ID_W-1:0] pick;
    logic cause_a;
    logic cause_b;
    logic restart_a;
    logic restart_b;
    logic expired_a;
    logic expired_b;
    logic accept_a;
    logic accept_b;
    logic any_reset;
    logic sys_a_trip;
    logic sys_b_trip;

    //////////////////////////////////////////////////////////////////////////

    // The raw contacts feed only the relay stage below; everything that
    // leaves the block is taken from the relay copy. [RULE19]
    assign sens_raw = {MAN_BUTTON_SYS_B_OK, MAN_BUTTON_SYS_A_OK,
                       SENS_AUTO_TWO_SYS_B, SENS_AUTO_ONE_SYS_B,
                       SENS_AUTO_TWO_SYS_A, SENS_AUTO_ONE_SYS_A};

    // One reset delay timer per trip system.
    reset_delay_timer #(
        .DELAY_CYC(RESET_DELAY_CYC)
    ) u_timer_a (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .restart(restart_a),
        .expired(expired_a)
    );

    reset_delay_timer #(
        .DELAY_CYC(RESET_DELAY_CYC)
    ) u_timer_b (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .restart(restart_b),
        .expired(expired_b)
    );

    //////////////////////////////////////////////////////////////////////////

    always_comb begin
        nxt_st = st_ff;
        relay_trip = ~st_ff.chan_ok;
        byp_eff = {2'b00, BYP_AUTO_TWO_SYS_B, BYP_AUTO_ONE_SYS_B,
                   BYP_AUTO_TWO_SYS_A, BYP_AUTO_ONE_SYS_A}; // [RULE3]
        var_trip = '0;
        cause = '0;
        pick = '0;

        // Outside run mode the steam isolation channels of every automatic
        // logic are bypassed without any operator action.
        for (int k = 0; k < 4; k++) begin
            if (!MODE_RUN) begin
                byp_eff[k * `STV_NVAR + `STV_STEAM_VAR] = 1'b1; // [RULE21]
            end
        end

        // Relay stage: an opened contact drops its channel relay.
        nxt_st.chan_ok = sens_raw; // [RULE8]
        eff_trip = relay_trip & ~byp_eff;
        new_trip = relay_trip & ~st_ff.prev_trip;
        new_eff = new_trip & ~byp_eff;
        nxt_st.prev_trip = relay_trip;

        // Each automatic logic opens on any unbypassed channel; the manual
        // logics open on their own button only.
        for (int k = 0; k < 4; k++) begin
            cause[k] = |eff_trip[k * `STV_NVAR +: `STV_NVAR]; // [RULE8]
        end
        cause[`STV_MANUAL_A] = eff_trip[`STV_MAN_A_CH]; // [RULE1] [RULE10]
        cause[`STV_MANUAL_B] = eff_trip[`STV_MAN_B_CH]; // [RULE10]

        cause_a = cause[`STV_AUTO_ONE_A] | cause[`STV_AUTO_TWO_A]
                | cause[`STV_MANUAL_A]; // [RULE20]
        cause_b = cause[`STV_AUTO_ONE_B] | cause[`STV_AUTO_TWO_B]
                | cause[`STV_MANUAL_B]; // [RULE20]

        // A fresh trip or a supply loss restarts the system's wait.
        restart_a = (|new_eff[0 +: 2 * `STV_NVAR]) | new_eff[`STV_MAN_A_CH]
                  | ~POWER_OK; // [RULE22]
        restart_b = (|new_eff[2 * `STV_NVAR +: 2 * `STV_NVAR])
                  | new_eff[`STV_MAN_B_CH] | ~POWER_OK; // [RULE22]

        // Reset is taken only after the delay and with every cause gone.
        accept_a = RESET_SW_SYS_A & expired_a & ~cause_a & POWER_OK
                 & ~restart_a; // [RULE13]
        accept_b = RESET_SW_SYS_B & expired_b & ~cause_b & POWER_OK
                 & ~restart_b; // [RULE13]

        // Actuators drop on their cause and stay down until reset; the
        // reset acts on one trip system only, so each can be tested alone.
        for (int l = 0; l < `STV_NLOGIC; l++) begin
            if (!POWER_OK || cause[l]) begin
                nxt_st.act_ok[l] = 1'b0; // [RULE12] [RULE13]
            end else if ((l == `STV_AUTO_ONE_A || l == `STV_AUTO_TWO_A ||
                          l == `STV_MANUAL_A) ? accept_a : accept_b) begin
                nxt_st.act_ok[l] = 1'b1; // [RULE11]
            end
        end

        // Any dropped actuator of a system trips that whole system.
        sys_a_trip = ~(nxt_st.act_ok[`STV_AUTO_ONE_A]
                     & nxt_st.act_ok[`STV_AUTO_TWO_A]
                     & nxt_st.act_ok[`STV_MANUAL_A]); // [RULE8] [RULE20]
        sys_b_trip = ~(nxt_st.act_ok[`STV_AUTO_ONE_B]
                     & nxt_st.act_ok[`STV_AUTO_TWO_B]
                     & nxt_st.act_ok[`STV_MANUAL_B]); // [RULE8] [RULE20]

        // Pilot A follows system A and pilot B system B; the rod stays
        // out while either is held, so one system alone cannot scram.
        nxt_st.pilot_a = ~sys_a_trip; // [RULE2] [RULE5]
        nxt_st.pilot_b = ~sys_b_trip; // [RULE2] [RULE5]
        nxt_st.backup = sys_a_trip & sys_b_trip; // [RULE6]
        nxt_st.rod_scram = (sys_a_trip & sys_b_trip)
                         | nxt_st.backup; // [RULE4] [RULE7] [RULE9]

        nxt_st.sys_a_ind = sys_a_trip; // [RULE15]
        nxt_st.sys_b_ind = sys_b_trip; // [RULE15]

        // Variable windows are shared by all channels of one variable and
        // latch; an operator reset clears only windows whose cause is gone.
        for (int v = 0; v < `STV_NVAR; v++) begin
            for (int k = 0; k < 4; k++) begin
                var_trip[v] = var_trip[v]
                            | relay_trip[k * `STV_NVAR + v]; // [RULE14]
            end
        end
        any_reset = RESET_SW_SYS_A | RESET_SW_SYS_B;
        for (int v = 0; v < `STV_NVAR; v++) begin
            if (var_trip[v]) begin
                nxt_st.var_ind[v] = 1'b1; // [RULE14]
            end else if (any_reset) begin
                nxt_st.var_ind[v] = 1'b0; // [RULE17]
            end
        end

        // A trip arriving with the acknowledge still sounds the alarm.
        if (|new_trip) begin
            nxt_st.alarm = 1'b1; // [RULE16]
        end else if (ALARM_ACK) begin
            nxt_st.alarm = 1'b0; // [RULE16]
        end

        // Logger: one channel identity per cycle. Trips of one cycle form a
        // batch sent lowest index first; later trips wait in a second set,
        // so order between cycles holds as long as the logger keeps up.
        batch_left = st_ff.batch;
        nxt_st.log_valid = 1'b0;
        if (st_ff.batch != '0) begin
            for (int i = `STV_NCH - 1; i >= 0; i--) begin
                if (st_ff.batch[i]) begin
                    pick = `STV_ID_W'(i);
                end
            end
            batch_left[pick] = 1'b0;
            nxt_st.log_valid = 1'b1; // [RULE18]
            nxt_st.log_id = pick; // [RULE18]
        end
        if (batch_left == '0) begin
            nxt_st.batch = st_ff.wait_set | new_trip; // [RULE18]
            nxt_st.wait_set = '0;
        end else begin
            nxt_st.batch = batch_left;
            nxt_st.wait_set = st_ff.wait_set | new_trip; // [RULE18]
        end
    end

    //////////////////////////////////////////////////////////////////////////

    // Reset leaves actuators, solenoids and system indications tripped, as after
    // a loss of supply; relays start dropped with their history set so start-up logs no events.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_ff.chan_ok <= '0; // [RULE12]
            st_ff.prev_trip <= '1;
            st_ff.act_ok <= '0; // [RULE12]
            st_ff.var_ind <= '0;
            st_ff.sys_a_ind <= 1'b1;
            st_ff.sys_b_ind <= 1'b1;
            st_ff.alarm <= 1'b0;
            st_ff.batch <= '0;
            st_ff.wait_set <= '0;
            st_ff.log_valid <= 1'b0;
            st_ff.log_id <= '0;
            st_ff.pilot_a <= 1'b0;
            st_ff.pilot_b <= 1'b0;
            st_ff.backup <= 1'b1;
            st_ff.rod_scram <= 1'b1;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////

    // Every rod gets one pilot from each system and the common backup.
    for (genvar r = 0; r < `STV_NROD; r++) begin : g_rod
        assign PILOT_SOL_SYS_A[r] = st_ff.pilot_a; // [RULE5]
        assign PILOT_SOL_SYS_B[r] = st_ff.pilot_b; // [RULE5]
        assign ROD_SCRAM_CMD[r] = st_ff.rod_scram; // [RULE4] [RULE7]
    end

    for (genvar b = 0; b < `STV_NBACKUP; b++) begin : g_backup
        assign BACKUP_SOL[b] = st_ff.backup; // [RULE6]
    end

    assign SYS_A_TRIP_IND = st_ff.sys_a_ind;
    assign SYS_B_TRIP_IND = st_ff.sys_b_ind;
    assign VAR_TRIP_IND = st_ff.var_ind;
    assign AUDIBLE_ALARM = st_ff.alarm;
    assign LOG_VALID = st_ff.log_valid;
    assign LOG_CHAN_ID = st_ff.log_id;
    assign RESET_PERMIT_SYS_A = expired_a;
    assign RESET_PERMIT_SYS_B = expired_b;

endmodule : scram_trip_voting_logic
`default_nettype wire

// ==== rtl/scram_trip_defs.svh ====
// Constants of the scram trip voting logic: sizes, channel layout, timing.
// Assumes a single 50 MHz system clock; included by package and modules.
`ifndef SCRAM_TRIP_DEFS_SVH
`define SCRAM_TRIP_DEFS_SVH

// Monitored variables, each seen by one channel in every automatic logic.
`define STV_NVAR 8
// Control rods served by the pilot solenoid outputs.
`define STV_NROD 4
// Channels: four automatic logics of STV_NVAR channels, then two buttons.
`define STV_NAUTO 32
`define STV_NCH 34
`define STV_ID_W 6
// Channel index of manual logic A and manual logic B.
`define STV_MAN_A_CH 32
`define STV_MAN_B_CH 33
// Logic numbering of the actuator vector.
`define STV_NLOGIC 6
`define STV_AUTO_ONE_A 0
`define STV_AUTO_TWO_A 1
`define STV_AUTO_ONE_B 2
`define STV_AUTO_TWO_B 3
`define STV_MANUAL_A 4
`define STV_MANUAL_B 5
// Variable index of the steam line isolation trip.
`define STV_STEAM_VAR 3
// Backup scram solenoids common to all rods.
`define STV_NBACKUP 2

// Reset delay in seconds and the clock rate in hertz.
`define STV_RESET_DELAY_S 10
`define STV_CLK_HZ 50000000
`define STV_RESET_DELAY_CYC (`STV_RESET_DELAY_S * `STV_CLK_HZ)
`define STV_CNT_W 29

`endif

// ==== rtl/scram_trip_pkg.sv ====
// Types of the scram trip voting logic.
// Assumes scram_trip_defs.svh is on the include path.
`include "scram_trip_defs.svh"

package scram_trip_pkg;

    typedef enum logic {
        TMR_TIMING,
        TMR_EXPIRED
    } timer_phase_t;

    typedef struct packed {
        timer_phase_t phase;
        logic [`STV_CNT_W-1:0] count;
    } timer_state_t;

    typedef struct packed {
        logic [`STV_NCH-1:0] chan_ok;
        logic [`STV_NCH-1:0] prev_trip;
        logic [`STV_NLOGIC-1:0] act_ok;
        logic [`STV_NVAR-1:0] var_ind;
        logic sys_a_ind;
        logic sys_b_ind;
        logic alarm;
        logic [`STV_NCH-1:0] batch;
        logic [`STV_NCH-1:0] wait_set;
        logic log_valid;
        logic [`STV_ID_W-1:0] log_id;
        logic pilot_a;
        logic pilot_b;
        logic backup;
        logic rod_scram;
    } stv_state_t;

endpackage : scram_trip_pkg

// ==== rtl/reset_delay_timer.sv ====
// Saturating delay timer that gates the manual reset of one trip system.
// Assumes restart comes from the voting logic: a pulse on a fresh trip, held high during a supply loss.
`timescale 1ns/1ps
`default_nettype none
`include "scram_trip_defs.svh"

module reset_delay_timer #(
    parameter logic [`STV_CNT_W-1:0] DELAY_CYC =
        `STV_CNT_W'(`STV_RESET_DELAY_CYC)
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control and status.
    input wire logic restart,
    output logic expired
);

    scram_trip_pkg::timer_state_t st_ff;
    scram_trip_pkg::timer_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (restart) begin
            // A new trip always starts the wait over again.
            nxt_st.phase = scram_trip_pkg::TMR_TIMING;
            nxt_st.count = '0;
        end else begin
            case (st_ff.phase)
                scram_trip_pkg::TMR_TIMING: begin
                    if (st_ff.count >= DELAY_CYC - `STV_CNT_W'(1)) begin
                        nxt_st.phase = scram_trip_pkg::TMR_EXPIRED;
                        nxt_st.count = DELAY_CYC;
                    end else begin
                        nxt_st.count = st_ff.count + `STV_CNT_W'(1);
                    end
                end
                scram_trip_pkg::TMR_EXPIRED: begin
                    nxt_st.count = DELAY_CYC;
                end
                default: begin
                    nxt_st.phase = scram_trip_pkg::TMR_TIMING;
                    nxt_st.count = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '{phase: scram_trip_pkg::TMR_TIMING, count: '0};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign expired = (st_ff.phase == scram_trip_pkg::TMR_EXPIRED);

endmodule : reset_delay_timer
`default_nettype wire

// ==== dv/scram_trip_monitor.sv ====
// Checker of the scram trip voting logic, bound to its top module ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "scram_trip_defs.svh"

module scram_trip_monitor (
    // Clock and control.
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic POWER_OK,
    // Contacts and operator panel.
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_ONE_SYS_A,
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_TWO_SYS_A,
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_ONE_SYS_B,
    input wire logic [`STV_NVAR-1:0] SENS_AUTO_TWO_SYS_B,
    input wire logic MAN_BUTTON_SYS_A_OK,
    input wire logic MAN_BUTTON_SYS_B_OK,
    input wire logic RESET_SW_SYS_A,
    input wire logic ALARM_ACK,
    // Outputs under watch.
    input wire logic [`STV_NROD-1:0] PILOT_SOL_SYS_A,
    input wire logic [`STV_NROD-1:0] PILOT_SOL_SYS_B,
    input wire logic [`STV_NBACKUP-1:0] BACKUP_SOL,
    input wire logic [`STV_NROD-1:0] ROD_SCRAM_CMD,
    input wire logic SYS_A_TRIP_IND,
    input wire logic SYS_B_TRIP_IND,
    input wire logic AUDIBLE_ALARM,
    input wire logic RESET_PERMIT_SYS_A,
    input wire logic LOG_VALID,
    input wire logic [`STV_ID_W-1:0] LOG_CHAN_ID
);
    // Reset counts as a cause, since relays come out of it dropped.
    logic [2:0] cause_ff;
    logic any_open;
    assign any_open = RST | ~POWER_OK | ~&{SENS_AUTO_ONE_SYS_A,
        SENS_AUTO_TWO_SYS_A, SENS_AUTO_ONE_SYS_B, SENS_AUTO_TWO_SYS_B,
        MAN_BUTTON_SYS_A_OK, MAN_BUTTON_SYS_B_OK};
    always_ff @(posedge CLK_SYS) begin
        cause_ff <= {cause_ff[1:0], any_open};
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    backup_both_a: assert property (BACKUP_SOL != '0 |->
        SYS_A_TRIP_IND && SYS_B_TRIP_IND) else $error("backup without both");
    rod_vote_a: assert property (ROD_SCRAM_CMD ==
        (~(PILOT_SOL_SYS_A | PILOT_SOL_SYS_B) | {`STV_NROD{|BACKUP_SOL}}))
        else $error("rod command disagrees with solenoids");
    single_trip_a: assert property (SYS_A_TRIP_IND != SYS_B_TRIP_IND |->
        ROD_SCRAM_CMD == '0) else $error("single system scrammed rods");
    trip_latch_a: assert property (SYS_A_TRIP_IND && !RESET_SW_SYS_A |=>
        SYS_A_TRIP_IND) else $error("system trip cleared without reset");
    reset_gate_a: assert property ($fell(SYS_A_TRIP_IND) |->
        $past(RESET_PERMIT_SYS_A) && $past(RESET_SW_SYS_A))
        else $error("reset accepted before permit");
    power_loss_a: assert property (CE && !POWER_OK |-> ##[1:2]
        (PILOT_SOL_SYS_A == '0 && PILOT_SOL_SYS_B == '0))
        else $error("power loss left pilots energized");
    manual_a_a: assert property (CE && !MAN_BUTTON_SYS_A_OK |-> ##[1:2]
        PILOT_SOL_SYS_A == '0) else $error("manual button did not trip");
    alarm_cause_a: assert property ($rose(AUDIBLE_ALARM) |->
        |cause_ff) else $error("alarm without channel trip");
    alarm_hold_a: assert property (AUDIBLE_ALARM && !ALARM_ACK |=>
        AUDIBLE_ALARM) else $error("alarm dropped without acknowledge");
    log_id_a: assert property (!LOG_VALID |-> $stable(LOG_CHAN_ID)
        ) else $error("logger id moved without pulse");

    cover property (ROD_SCRAM_CMD == '1 && BACKUP_SOL == '1);
    cover property (LOG_VALID && $past(LOG_VALID));
    cover property ($fell(SYS_A_TRIP_IND));
endmodule : scram_trip_monitor

bind scram_trip_voting_logic scram_trip_monitor mon (.*);
`default_nettype wire

// ==== dv/scram_field_model.sv ====
// Field side model: sensor contacts, scram buttons and the trip logger.
// Assumes the bench calls set_open just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "scram_trip_defs.svh"

module scram_field_model (
    // Clock.
    input wire logic clk,
    // Contacts, closed and high while healthy.
    output logic [`STV_NVAR-1:0] sens_oa,
    output logic [`STV_NVAR-1:0] sens_ta,
    output logic [`STV_NVAR-1:0] sens_ob,
    output logic [`STV_NVAR-1:0] sens_tb,
    output logic man_a_ok,
    output logic man_b_ok,
    // Logger feed.
    input wire logic log_valid,
    input wire logic [`STV_ID_W-1:0] log_id
);
    logic [`STV_NCH-1:0] open_ff = '0;
    logic [`STV_ID_W-1:0] log_q[$];
    assign sens_oa = ~open_ff[7:0];
    assign sens_ta = ~open_ff[15:8];
    assign sens_ob = ~open_ff[23:16];
    assign sens_tb = ~open_ff[31:24];
    assign man_a_ok = ~open_ff[`STV_MAN_A_CH];
    assign man_b_ok = ~open_ff[`STV_MAN_B_CH];

    task automatic set_open(input logic [`STV_NCH-1:0] v);
        @(posedge clk);
        #1;
        open_ff = v;
    endtask : set_open

    // The logger offers no back-pressure, so it must take every pulse.
    always @(posedge clk) begin
        if (log_valid === 1'b1) begin
            log_q.push_back(log_id);
        end
    end
endmodule : scram_field_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench of the scram trip voting logic.
// Assumes the field model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "scram_trip_defs.svh"

module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic mode_run = 1'b1;
    logic power_ok = 1'b1;
    logic rst_sw_a = 1'b0;
    logic rst_sw_b = 1'b0;
    logic alarm_ack = 1'b0;
    logic ce = 1'b1;
    logic [7:0] byp = 8'h00;
    wire logic [7:0] s_oa, s_ta, s_ob, s_tb;
    wire logic man_a, man_b;
    logic [3:0] pil_a, pil_b, rod;
    logic [1:0] backup;
    logic [7:0] var_ind;
    logic [5:0] log_id;
    logic ind_a, ind_b, alarm, perm_a, perm_b, log_v;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    always #10 clk_sys = ~clk_sys;

    // A short delay count keeps every reset wait to a few dozen cycles.
    scram_trip_voting_logic #(.RESET_DELAY_CYC(`STV_CNT_W'(20))) dut (
        .CLK_SYS(clk_sys), .RST(rst), .CE(ce),
        .SENS_AUTO_ONE_SYS_A(s_oa), .SENS_AUTO_TWO_SYS_A(s_ta),
        .SENS_AUTO_ONE_SYS_B(s_ob), .SENS_AUTO_TWO_SYS_B(s_tb),
        .BYP_AUTO_ONE_SYS_A(byp), .BYP_AUTO_TWO_SYS_A(byp),
        .BYP_AUTO_ONE_SYS_B(byp), .BYP_AUTO_TWO_SYS_B(byp),
        .MODE_RUN(mode_run), .POWER_OK(power_ok),
        .MAN_BUTTON_SYS_A_OK(man_a), .MAN_BUTTON_SYS_B_OK(man_b),
        .RESET_SW_SYS_A(rst_sw_a), .RESET_SW_SYS_B(rst_sw_b),
        .ALARM_ACK(alarm_ack), .PILOT_SOL_SYS_A(pil_a),
        .PILOT_SOL_SYS_B(pil_b), .BACKUP_SOL(backup), .ROD_SCRAM_CMD(rod),
        .SYS_A_TRIP_IND(ind_a), .SYS_B_TRIP_IND(ind_b),
        .VAR_TRIP_IND(var_ind), .AUDIBLE_ALARM(alarm),
        .RESET_PERMIT_SYS_A(perm_a), .RESET_PERMIT_SYS_B(perm_b),
        .LOG_VALID(log_v), .LOG_CHAN_ID(log_id)
    );

    scram_field_model field (
        .clk(clk_sys), .sens_oa(s_oa), .sens_ta(s_ta), .sens_ob(s_ob),
        .sens_tb(s_tb), .man_a_ok(man_a), .man_b_ok(man_b),
        .log_valid(log_v), .log_id(log_id)
    );

    //////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic sol(input logic [15:0] exp);
        check("solenoids", {pil_a, pil_b, rod, backup, ind_a, ind_b}, exp);
    endtask : sol

    task automatic log_is(input logic [5:0] id);
        check("log id", field.log_q.size() > 0 ?
              64'(field.log_q.pop_front()) : 64'hFFFF, id);
    endtask : log_is

    task automatic ack();
        alarm_ack = 1'b1;
        step(1);
        alarm_ack = 1'b0;
    endtask : ack

    // Both switches are held until both systems read healthy again.
    task automatic do_reset();
        int n = 0;
        rst_sw_a = 1'b1;
        rst_sw_b = 1'b1;
        while ((ind_a !== 1'b0 || ind_b !== 1'b0) && n < 100) begin
            step(1);
            n++;
        end
        step(1);
        rst_sw_a = 1'b0;
        rst_sw_b = 1'b0;
        check("reset wait", n < 100, 1);
    endtask : do_reset

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            final_report();
        end
    end

    //////////////////////////////////////////////////////////////////////
    initial begin
        step(8);
        rst = 1'b0;
        step(1);
        sol({4'h0, 4'h0, 4'hF, 2'h3, 2'h3});
        check("var windows", var_ind, 8'hFF);
        check("permits", {perm_a, perm_b}, 2'h0);
        do_reset();
        sol({4'hF, 4'hF, 4'h0, 2'h0, 2'h0});
        check("var windows", var_ind, 8'h00);
        ack();
        field.log_q.delete();
        // One automatic channel of system A opens.
        field.set_open(34'h4);
        step(3);
        sol({4'h0, 4'hF, 4'h0, 2'h0, 2'h2});
        check("var windows", var_ind, 8'h04);
        check("alarm", alarm, 1);
        check("permits", {perm_a, perm_b}, 2'h1);
        step(3);
        log_is(6'h02);
        rst_sw_a = 1'b1;
        step(30);
        rst_sw_a = 1'b0;
        check("held trip", ind_a, 1);
        check("var windows", var_ind, 8'h04);
        ack();
        check("alarm", alarm, 0);
        field.set_open(34'h0);
        do_reset();
        sol({4'hF, 4'hF, 4'h0, 2'h0, 2'h0});
        check("var windows", var_ind, 8'h00);
        // Manual buttons, one system at a time, then both.
        field.set_open(34'h1_0000_0000);
        step(3);
        sol({4'h0, 4'hF, 4'h0, 2'h0, 2'h2});
        field.set_open(34'h0);
        do_reset();
        field.set_open(34'h2_0000_0000);
        step(3);
        sol({4'hF, 4'h0, 4'h0, 2'h0, 2'h1});
        field.set_open(34'h3_0000_0000);
        step(3);
        sol({4'h0, 4'h0, 4'hF, 2'h3, 2'h3});
        step(3);
        log_is(6'h20);
        log_is(6'h21);
        log_is(6'h20);
        field.set_open(34'h0);
        do_reset();
        ack();
        // Two channels of opposite systems open in the same cycle.
        field.set_open(34'h2_0200);
        step(6);
        sol({4'h0, 4'h0, 4'hF, 2'h3, 2'h3});
        check("var windows", var_ind, 8'h02);
        log_is(6'h09);
        log_is(6'h11);
        field.set_open(34'h0);
        do_reset();
        ack();
        // Bypassed channels of variable 1 in all four logics still sound the alarm but trip nothing.
        byp = 8'h02;
        field.set_open(34'h202_0202);
        step(3);
        sol({4'hF, 4'hF, 4'h0, 2'h0, 2'h0});
        check("alarm", alarm, 1);
        byp = 8'h00;
        step(3);
        sol({4'h0, 4'h0, 4'hF, 2'h3, 2'h3});
        field.set_open(34'h0);
        do_reset();
        // Steam isolation trip is ignored outside run mode.
        mode_run = 1'b0;
        field.set_open(34'h8);
        step(3);
        check("pilots a", pil_a, 4'hF);
        mode_run = 1'b1;
        step(3);
        check("pilots a", pil_a, 4'h0);
        field.set_open(34'h0);
        do_reset();
        ce = 1'b0;
        field.set_open(34'h1);
        step(3);
        check("frozen", pil_a, 4'hF);
        ce = 1'b1;
        step(3);
        check("pilots a", pil_a, 4'h0);
        field.set_open(34'h0);
        do_reset();
        power_ok = 1'b0;
        step(3);
        check("power loss", {pil_a, pil_b, rod}, 12'h00F);
        power_ok = 1'b1;
        do_reset();
        sol({4'hF, 4'hF, 4'h0, 2'h0, 2'h0});
        final_report();
    end
endmodule : tb_top
`default_nettype wire
